// ### logic/ldc_pkg.sv
// package of constants and types for the long-mode descriptor check block
//
// Contract
// [R1] compatibility mode decodes a code descriptor exactly like legacy operation
// [R2] a load keeps every descriptor field, including fields later references ignore
// [R3] 64-bit mode forms code addresses with a zero base
// [R4] 64-bit code skips limit and granularity; addresses are checked for canonical form
// [R5] 64-bit code ignores readable and accessed type attributes
// [R6] long-mode select is bit 21 of dword +4: one means 64-bit, zero compatibility
// [R7] under legacy operation the long-mode select bit is reserved and meaningless
// [R8] select bit zero keeps segmentation and the legacy default-size bit
// [R9] select bit set needs default-size zero: 32-bit operands, 64-bit addresses; both set reserved
// [R10] compatibility mode applies data descriptors with legacy behaviour
// [R11] 64-bit mode uses zero base for default, extra and stack data selectors
// [R12] 64-bit mode applies extra-base selector bases, full 64-bit values held in registers
// [R13] 64-bit data segments get no limit check; limit, granularity, default-size ignored
// [R14] 64-bit data ignores expand-down, writable and accessed attributes
// [R15] 64-bit data ignores privilege level and skips privilege checks
// [R16] long mode system types 0,1,3-8,A,D are illegal and fault
// [R17] long mode types 2, 9, B mean 64-bit local table, available and busy task state
// [R18] compatibility mode uses legacy system format and a 32-bit local table
// [R19] 64-bit mode reads expanded system descriptors; only 64-bit mode loads them
// [R20] a system load checks its 64-bit base is canonical, else faults with the selector
// [R21] system limits are checked in both long modes, scaled by granularity
// [R22] upper half of an expanded descriptor has bits 12:8 clear; using it faults
// [R23] mode and selecting register steer every decode; fault type and error code report together
package ldc_pkg;

    localparam int ADR_W = 8;

    // register byte offsets
    localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00, OFS_DESC0 = 8'h04, OFS_DESC1 = 8'h08, OFS_DESC2 = 8'h0c,
        OFS_DESC3 = 8'h10, OFS_SELECTOR = 8'h14, OFS_VA_LO = 8'h18, OFS_VA_HI = 8'h1c, OFS_FSB_LO = 8'h20,
        OFS_FSB_HI = 8'h24, OFS_GSB_LO = 8'h28, OFS_GSB_HI = 8'h2c, OFS_STATUS = 8'h30, OFS_ERROR = 8'h34,
        OFS_HBASE_LO = 8'h38, OFS_HBASE_HI = 8'h3c, OFS_HLIMIT = 8'h40, OFS_HATTR = 8'h44, OFS_LIN_LO = 8'h48,
        OFS_LIN_HI = 8'h4c;

    // control register fields
    localparam int CTRL_MODE = 0, CTRL_SEG = 2, CTRL_CPL = 5, CTRL_WR = 7, CTRL_GO = 8;

    // status register fields
    localparam int ST_DONE = 0, ST_FAULT = 1, ST_KIND = 2, ST_OP32 = 5, ST_ADR64 = 6;

    // descriptor fields: dword +0
    localparam int F_LIM_LO = 0, F_BASE_LO = 16;
    // descriptor fields: dword +4
    localparam int F_BASE_MID = 0, F_TYPE = 8, F_S = 12, F_PRIV_LEVEL = 13, F_P = 15, F_LIM_HI = 16, F_L = 21;
    localparam int F_D = 22, F_G = 23, F_BASE_HI = 24, F_ATTR = 8;
    // bits 12:8 of dword +12 in an expanded system descriptor
    localparam int F_UPPER_ST = 8;

    // type field codes and attribute bit positions inside the type
    localparam logic [3:0] T_LOCAL_TABLE = 4'h2, T_TASK_STATE_AVL16 = 4'h1, T_TASK_STATE_AVL = 4'h9;
    localparam int T_CODE = 3, T_EXPDN = 2, T_RW = 1;
    localparam logic [15:0] ILLEGAL_LONG = 16'h25fb, ILLEGAL_LEGACY = 16'h2501;

    localparam logic [19:0] GRAN_FILL = 20'h0_0fff;
    localparam logic [31:0] UPPER_BIG = 32'hffff_ffff;
    localparam logic [31:0] UPPER_SMALL = 32'h0000_ffff;

    typedef enum logic [1:0] {
        MODE_LEGACY = 2'b00,
        MODE_COMPAT = 2'b01,
        MODE_64 = 2'b10
    } ldc_mode_t;

    typedef enum logic [2:0] {
        SR_CS = 3'b000,
        SR_SS = 3'b001,
        SR_DEFAULT_DATA = 3'b010,
        SR_EXTRA_DATA = 3'b011,
        SR_FIRST_EXTRA_BASE = 3'b100,
        SR_SECOND_EXTRA_BASE = 3'b101,
        SR_LOCAL_TABLE = 3'b110,
        SR_TASK_REGISTER = 3'b111
    } ldc_seg_t;

    typedef enum logic [2:0] {
        FLT_NONE = 3'b000,
        FLT_TYPE = 3'b001,
        FLT_NOT_PRESENT = 3'b010,
        FLT_CANON = 3'b011,
        FLT_LIMIT = 3'b100,
        FLT_PRIV = 3'b101,
        FLT_RESERVED = 3'b110
    } ldc_fault_t;

endpackage

// ### logic/ldc_descriptor_check.sv
// long-mode segment descriptor decoder and checker with a wishbone register port
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module ldc_descriptor_check #(
    parameter int VA_BITS = 48
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ldc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic done_o,
    output logic fault_o,
    output ldc_pkg::ldc_fault_t fault_kind_o,
    output logic [15:0] error_code_o
);
    import ldc_pkg::*;

    // whole block state in one record
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        ldc_mode_t mode;
        ldc_seg_t seg;
        logic [1:0] cpl;
        logic wr;
        logic go;
        logic [3:0][31:0] desc;
        logic [15:0] sel;
        logic [63:0] va;
        logic [63:0] first_base;
        logic [63:0] second_base;
        logic done;
        logic fault;
        ldc_fault_t kind;
        logic [15:0] err;
        logic op32;
        logic adr64;
        logic [63:0] hbase;
        logic [31:0] hlim;
        logic [15:0] hattr;
        logic [63:0] lin;
    } ldc_state_t;

    ldc_state_t s;
    ldc_state_t next_s;

    // decoded descriptor fields
    logic [31:0] d0;
    logic [31:0] d1;
    logic [31:0] base32;
    logic [19:0] lim_raw;
    logic [31:0] lim_sc;
    logic [3:0] typ;
    logic s_bit;
    logic present;
    logic [1:0] priv_lvl;
    logic long_mode;
    logic in64;
    logic l_bit;
    logic [15:0] sel_err;

    // check results
    ldc_fault_t flt;
    logic [15:0] err;
    logic [63:0] eff_base;
    logic [63:0] hid_base;
    logic [63:0] lin;
    logic op32;
    logic adr64;
    logic [15:0] illegal;
    logic [31:0] upper;
    logic [31:0] rd;
    logic req;

    // true when bits 63 down to the top implemented bit all agree
    function automatic logic canon(input logic [63:0] x);
        canon = (&x[63:VA_BITS-1]) | ~(|x[63:VA_BITS-1]);
    endfunction

    // byte-lane merge for a wishbone write
    function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        lanes = r;
    endfunction

    // legacy field extraction, shared by every mode
    assign d0 = s.desc[0];
    assign d1 = s.desc[1];
    assign base32 = {d1[F_BASE_HI +: 8], d1[F_BASE_MID +: 8], d0[F_BASE_LO +: 16]};
    assign lim_raw = {d1[F_LIM_HI +: 4], d0[F_LIM_LO +: 16]};
    assign lim_sc = d1[F_G] ? {lim_raw, GRAN_FILL[11:0]} : {12'h000, lim_raw}; // [R1] [R21]
    assign typ = d1[F_TYPE +: 4];
    assign s_bit = d1[F_S];
    assign present = d1[F_P];
    assign priv_lvl = d1[F_PRIV_LEVEL +: 2];
    assign long_mode = (s.mode != MODE_LEGACY);
    assign in64 = (s.mode == MODE_64);
    assign l_bit = long_mode & d1[F_L]; // [R6] [R7]
    assign sel_err = {s.sel[15:2], 2'b00};
    assign illegal = long_mode ? ILLEGAL_LONG : ILLEGAL_LEGACY; // [R16]
    assign upper = d1[F_D] ? UPPER_BIG : UPPER_SMALL;
    assign req = wb_cyc_i & wb_stb_i & ~s.ack;

    // descriptor check, steered by mode and the selecting register
    always_comb begin // [R23]
        flt = FLT_NONE;
        err = 16'h0000;
        eff_base = {32'h0000_0000, base32};
        hid_base = {32'h0000_0000, base32}; // [R2]
        op32 = 1'b0;
        adr64 = 1'b0;
        case (s.seg)
            SR_CS: begin
                if (!s_bit || !typ[T_CODE]) begin
                    flt = FLT_TYPE;
                    err = sel_err;
                end else if (!present) begin
                    flt = FLT_NOT_PRESENT;
                    err = sel_err;
                end else if (l_bit && d1[F_D]) begin
                    flt = FLT_RESERVED; // [R9]
                    err = sel_err;
                end else if (l_bit) begin
                    // base is zero, no limit, readable and accessed not looked at
                    eff_base = 64'h0000_0000_0000_0000; // [R3] [R5]
                    op32 = 1'b1; // [R9]
                    adr64 = 1'b1;
                    if (!canon(s.va)) begin
                        flt = FLT_CANON; // [R4]
                    end
                end else begin
                    op32 = d1[F_D]; // [R8]
                    if (s.va[63:32] != 32'h0000_0000 || s.va[31:0] > lim_sc) begin
                        flt = FLT_LIMIT; // [R1] [R8]
                    end
                end
            end
            SR_SS, SR_DEFAULT_DATA, SR_EXTRA_DATA, SR_FIRST_EXTRA_BASE, SR_SECOND_EXTRA_BASE: begin
                if (!s_bit || (typ[T_CODE] && !typ[T_RW])) begin
                    flt = FLT_TYPE;
                    err = sel_err;
                end else if (!present) begin
                    flt = FLT_NOT_PRESENT;
                    err = sel_err;
                end else if (in64) begin
                    // limit, granularity, size, attributes and privilege all ignored here
                    if (s.seg == SR_FIRST_EXTRA_BASE) begin
                        eff_base = s.first_base; // [R12]
                    end else if (s.seg == SR_SECOND_EXTRA_BASE) begin
                        eff_base = s.second_base; // [R12]
                    end else begin
                        eff_base = 64'h0000_0000_0000_0000; // [R11]
                    end
                    if (!canon(eff_base + s.va)) begin
                        flt = FLT_CANON; // [R13] [R14] [R15]
                    end
                end else if (!typ[T_CODE] && (priv_lvl < s.cpl || priv_lvl < s.sel[1:0])) begin
                    flt = FLT_PRIV; // [R10]
                    err = sel_err;
                end else if (s.wr && (typ[T_CODE] || !typ[T_RW])) begin
                    flt = FLT_PRIV; // [R10]
                end else if (s.va[63:32] != 32'h0000_0000) begin
                    flt = FLT_LIMIT;
                end else if (!typ[T_CODE] && typ[T_EXPDN]) begin
                    // expand-down: valid offsets lie above the limit
                    if (s.va[31:0] <= lim_sc || s.va[31:0] > upper) begin
                        flt = FLT_LIMIT; // [R10]
                    end
                end else if (s.va[31:0] > lim_sc) begin
                    flt = FLT_LIMIT; // [R10]
                end
            end
            SR_LOCAL_TABLE, SR_TASK_REGISTER: begin
                if (s_bit || illegal[typ]) begin
                    flt = FLT_TYPE; // [R16] [R22]
                    err = sel_err;
                end else if (s.seg == SR_LOCAL_TABLE && typ != T_LOCAL_TABLE) begin
                    flt = FLT_TYPE; // [R17] [R18]
                    err = sel_err;
                end else if (s.seg == SR_TASK_REGISTER && typ != T_TASK_STATE_AVL
                        && (long_mode || typ != T_TASK_STATE_AVL16)) begin
                    flt = FLT_TYPE; // [R17]
                    err = sel_err;
                end else if (!present) begin
                    flt = FLT_NOT_PRESENT;
                    err = sel_err;
                end else if (in64 && s.desc[3][F_UPPER_ST +: 5] != 5'b00000) begin
                    flt = FLT_TYPE; // [R22]
                    err = sel_err;
                end else begin
                    // expanded format only from 64-bit mode, legacy format otherwise
                    if (in64) begin
                        hid_base = {s.desc[2], base32}; // [R19]
                    end
                    eff_base = hid_base; // [R18]
                    if (in64 && !canon(hid_base)) begin
                        flt = FLT_CANON; // [R20]
                        err = sel_err;
                    end else if (s.va[63:32] != 32'h0000_0000 || s.va[31:0] > lim_sc) begin
                        flt = FLT_LIMIT; // [R21]
                    end
                end
            end
            default: begin
                flt = FLT_TYPE;
                err = sel_err;
            end
        endcase
        lin = eff_base + s.va;
    end

    // register read mux; unmapped addresses read as zero
    always_comb begin
        rd = 32'h0000_0000;
        case (wb_adr_i)
            OFS_CTRL: begin
                rd[CTRL_MODE +: 2] = s.mode;
                rd[CTRL_SEG +: 3] = s.seg;
                rd[CTRL_CPL +: 2] = s.cpl;
                rd[CTRL_WR] = s.wr;
            end
            OFS_DESC0: rd = s.desc[0];
            OFS_DESC1: rd = s.desc[1];
            OFS_DESC2: rd = s.desc[2];
            OFS_DESC3: rd = s.desc[3];
            OFS_SELECTOR: rd = {16'h0000, s.sel};
            OFS_VA_LO: rd = s.va[31:0];
            OFS_VA_HI: rd = s.va[63:32];
            OFS_FSB_LO: rd = s.first_base[31:0];
            OFS_FSB_HI: rd = s.first_base[63:32];
            OFS_GSB_LO: rd = s.second_base[31:0];
            OFS_GSB_HI: rd = s.second_base[63:32];
            OFS_STATUS: begin
                rd[ST_DONE] = s.done;
                rd[ST_FAULT] = s.fault;
                rd[ST_KIND +: 3] = s.kind;
                rd[ST_OP32] = s.op32;
                rd[ST_ADR64] = s.adr64;
            end
            OFS_ERROR: rd = {16'h0000, s.err};
            OFS_HBASE_LO: rd = s.hbase[31:0];
            OFS_HBASE_HI: rd = s.hbase[63:32];
            OFS_HLIMIT: rd = s.hlim;
            OFS_HATTR: rd = {16'h0000, s.hattr};
            OFS_LIN_LO: rd = s.lin[31:0];
            OFS_LIN_HI: rd = s.lin[63:32];
            default: rd = 32'h0000_0000;
        endcase
    end

    // next-state: latch a check one cycle after go, then serve the bus
    always_comb begin
        next_s = s;
        next_s.ack = 1'b0;
        next_s.go = 1'b0;
        // results latch whole, so fault kind and error code never disagree
        if (s.go) begin
            next_s.done = 1'b1;
            next_s.fault = (flt != FLT_NONE); // [R23]
            next_s.kind = flt;
            next_s.err = err;
            next_s.op32 = op32;
            next_s.adr64 = adr64;
            next_s.hbase = hid_base; // [R2]
            next_s.hlim = lim_sc;
            next_s.hattr = d1[F_ATTR +: 16]; // [R2]
            next_s.lin = lin;
        end
        // single-cycle slave: ack the cycle after the request is seen
        if (req) begin
            next_s.ack = 1'b1;
            next_s.dat = rd;
            if (wb_we_i) begin
                next_s.dat = 32'h0000_0000;
                case (wb_adr_i)
                    OFS_CTRL: begin
                        if (wb_sel_i[0]) begin
                            next_s.mode = ldc_mode_t'(wb_dat_i[CTRL_MODE +: 2]);
                            next_s.seg = ldc_seg_t'(wb_dat_i[CTRL_SEG +: 3]);
                            next_s.cpl = wb_dat_i[CTRL_CPL +: 2];
                            next_s.wr = wb_dat_i[CTRL_WR];
                        end
                        // a fresh start clears done so software sees the new answer
                        if (wb_sel_i[1] && wb_dat_i[CTRL_GO]) begin
                            next_s.go = 1'b1;
                            next_s.done = 1'b0;
                        end
                    end
                    OFS_DESC0: next_s.desc[0] = lanes(s.desc[0], wb_dat_i, wb_sel_i);
                    OFS_DESC1: next_s.desc[1] = lanes(s.desc[1], wb_dat_i, wb_sel_i);
                    OFS_DESC2: next_s.desc[2] = lanes(s.desc[2], wb_dat_i, wb_sel_i);
                    OFS_DESC3: next_s.desc[3] = lanes(s.desc[3], wb_dat_i, wb_sel_i);
                    OFS_SELECTOR: next_s.sel = 16'(lanes({16'h0000, s.sel}, wb_dat_i, wb_sel_i));
                    OFS_VA_LO: next_s.va[31:0] = lanes(s.va[31:0], wb_dat_i, wb_sel_i);
                    OFS_VA_HI: next_s.va[63:32] = lanes(s.va[63:32], wb_dat_i, wb_sel_i);
                    OFS_FSB_LO: next_s.first_base[31:0] = lanes(s.first_base[31:0], wb_dat_i, wb_sel_i); // [R12]
                    OFS_FSB_HI: next_s.first_base[63:32] = lanes(s.first_base[63:32], wb_dat_i, wb_sel_i);
                    OFS_GSB_LO: next_s.second_base[31:0] = lanes(s.second_base[31:0], wb_dat_i, wb_sel_i);
                    OFS_GSB_HI: next_s.second_base[63:32] = lanes(s.second_base[63:32], wb_dat_i, wb_sel_i);
                    default: next_s.dat = 32'h0000_0000;
                endcase
            end
        end
    end

    // state register; synchronous reset to all zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from state flops
    assign wb_dat_o = s.dat;
    assign wb_ack_o = s.ack;
    assign done_o = s.done;
    assign fault_o = s.fault;
    assign fault_kind_o = s.kind;
    assign error_code_o = s.err;

endmodule // ldc_descriptor_check

// ### bench/ldc_descriptor_check_assertions.sv
// assertion checker that watches the descriptor check block at its ports
`timescale 1ns/1ps

module ldc_descriptor_check_assertions
    import ldc_pkg::*;
#(
    parameter int VA_BITS = 48
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ldc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic done_o,
    input wire logic fault_o,
    input wire ldc_pkg::ldc_fault_t fault_kind_o,
    input wire logic [15:0] error_code_o
);
    logic go_w;

    // a check is launched only by a taken write that carries the go bit
    assign go_w = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == OFS_CTRL && wb_sel_i[1] && wb_dat_i[CTRL_GO];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_launch;
        go_w;
    endsequence
    // done drops in the ack cycle and returns with the result one cycle later
    sequence s_result;
        !done_o ##1 done_o;
    endsequence

    AST_ACK_NEXT: assert property (s_take |=> wb_ack_o)
        else $error("ack missing one cycle after a taken request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    AST_WR_DATA: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero on a write");
    AST_DONE_SEQ: assert property (s_launch |=> s_result)
        else $error("result not ready two cycles after go");
    AST_DONE_CAUSE: assert property ($rose(done_o) |-> $past(go_w, 2))
        else $error("done rose without a go write");
    AST_KIND_FAULT: assert property (fault_o == (fault_kind_o != FLT_NONE))
        else $error("fault flag and fault kind disagree");
    AST_CLEAN: assert property (!fault_o |-> error_code_o == 16'h0000)
        else $error("error code set without a fault");
    AST_LIMIT_ERR: assert property (fault_kind_o == FLT_LIMIT |-> error_code_o == 16'h0000)
        else $error("limit fault with nonzero error code");
    AST_ERR_RPL: assert property (error_code_o[1:0] == 2'b00)
        else $error("error code low bits not cleared");
    AST_HOLD: assert property (done_o && !go_w |=> done_o && $stable({fault_o, fault_kind_o, error_code_o}))
        else $error("result changed without a new check");
endmodule // ldc_descriptor_check_assertions

bind ldc_descriptor_check ldc_descriptor_check_assertions #(.VA_BITS(VA_BITS)) u_chk (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .done_o, .fault_o, .fault_kind_o, .error_code_o
);

// ### bench/ldc_desc_table.sv
// descriptor table model: entries that system software has built in memory
`timescale 1ns/1ps

module ldc_desc_table (
    input wire logic [2:0] index_i,
    output logic [31:0] dw0_o,
    output logic [31:0] dw1_o,
    output logic [31:0] dw2_o,
    output logic [31:0] dw3_o
);
    // dwords +0..+12 of each entry; entries 1, 4 and 5 are deliberately broken by software
    always_comb begin
        dw0_o = 32'h0000_00ff;
        dw1_o = 32'h0000_0000;
        dw2_o = 32'h0000_0000;
        dw3_o = 32'h0000_0000;
        case (index_i)
            3'h0: dw1_o = 32'h1220_9834; // 64-bit code keeps the size bit clear
            3'h1: dw1_o = 32'h1260_9834; // both long and size bits set
            3'h2: dw1_o = 32'h1200_9034;
            3'h3, 3'h4, 3'h5: begin
                dw0_o = 32'h0000_0001;
                dw1_o = 32'h0080_8200;
                dw2_o = (index_i == 3'h4) ? 32'h0000_8000 : 32'h0000_1234;
                dw3_o = (index_i == 3'h5) ? 32'h0000_1f00 : 32'h0000_0000;
            end
            default: dw0_o = 32'h0000_0000;
        endcase
    end
endmodule // ldc_desc_table

// ### bench/ldc_descriptor_check_test.sv
// self-checking testbench for the long-mode descriptor check block
`timescale 1ns/1ps

module ldc_descriptor_check_test;
    import ldc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [ADR_W-1:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic done_o;
    logic fault_o;
    ldc_fault_t fault_kind_o;
    logic [15:0] error_code_o;
    logic [2:0] tbl_idx = 3'h0;
    logic [31:0] dw0, dw1, dw2, dw3;
    int mismatches = 0;
    int cmp_count = 0;

    ldc_descriptor_check #(.VA_BITS(48)) u_ldc_descriptor_check (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .done_o, .fault_o, .fault_kind_o, .error_code_o
    );
    ldc_desc_table u_tbl (.index_i(tbl_idx), .dw0_o(dw0), .dw1_o(dw1), .dw2_o(dw2), .dw3_o(dw3));

    // 125 MHz core clock
    always #4 clk_i = ~clk_i;

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic cycle; waits for ack as long as it takes, only the watchdog ends a hang
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] v;
        xfer(1'b1, adr, dat, v);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] v;
        xfer(1'b0, adr, 32'h0000_0000, v);
        check(v, exp);
    endtask

    // load an entry from the table (dword +4 bits flipped by tx), launch a check, compare the verdict
    task automatic run(input ldc_mode_t m, input ldc_seg_t s, input logic [1:0] cpl, input logic w,
            input logic [2:0] idx, input logic [31:0] tx, input logic [15:0] sel, input logic [63:0] va,
            input logic f, input ldc_fault_t k, input logic [15:0] err);
        tbl_idx = idx;
        @(posedge clk_i);
        wr(OFS_DESC0, dw0);
        wr(OFS_DESC1, dw1 ^ tx);
        wr(OFS_DESC2, dw2);
        wr(OFS_DESC3, dw3);
        wr(OFS_SELECTOR, {16'h0000, sel});
        wr(OFS_VA_LO, va[31:0]);
        wr(OFS_VA_HI, va[63:32]);
        wr(OFS_CTRL, {23'h00_0000, 1'b1, w, cpl, s, m});
        // the verdict latches at the edge after ack, so done must already stand here
        check({done_o, fault_o, fault_kind_o, error_code_o}, {1'b1, f, k, err});
    endtask

    task automatic t_regs();
        rd_chk(OFS_STATUS, 32'h0000_0000);
        wr(OFS_DESC0, 32'h1234_5678);
        rd_chk(OFS_DESC0, 32'h1234_5678);
        wr(8'h50, 32'hffff_ffff);
        rd_chk(8'h50, 32'h0000_0000);
        wr(OFS_STATUS, 32'hffff_ffff);
        rd_chk(OFS_STATUS, 32'h0000_0000);
    endtask

    task automatic t_code();
        run(MODE_64, SR_CS, 2'h0, 1'b0, 3'h0, 32'h0, 16'h0008, 64'h1000, 1'b0, FLT_NONE, 16'h0);
        rd_chk(OFS_LIN_LO, 32'h0000_1000);
        rd_chk(OFS_LIN_HI, 32'h0000_0000);
        rd_chk(OFS_STATUS, 32'h0000_0061);
        rd_chk(OFS_HATTR, 32'h0000_2098);
        run(MODE_64, SR_CS, 2'h0, 1'b0, 3'h0, 32'h0, 16'h0008, 64'h0000_8000_0000_0000, 1'b1, FLT_CANON, 16'h0);
        run(MODE_64, SR_CS, 2'h0, 1'b0, 3'h1, 32'h0, 16'h0010, 64'h10, 1'b1, FLT_RESERVED, 16'h0010);
        run(MODE_LEGACY, SR_CS, 2'h0, 1'b0, 3'h1, 32'h0, 16'h0010, 64'h10, 1'b0, FLT_NONE, 16'h0);
        run(MODE_COMPAT, SR_CS, 2'h0, 1'b0, 3'h0, 32'h0020_0000, 16'h0008, 64'h1000, 1'b1, FLT_LIMIT, 16'h0);
    endtask

    task automatic t_data();
        run(MODE_64, SR_DEFAULT_DATA, 2'h3, 1'b1, 3'h2, 32'h0, 16'h0013, 64'h1000, 1'b0, FLT_NONE, 16'h0);
        rd_chk(OFS_LIN_LO, 32'h0000_1000);
        wr(OFS_FSB_LO, 32'h0000_0000);
        wr(OFS_FSB_HI, 32'h0000_0001);
        run(MODE_64, SR_FIRST_EXTRA_BASE, 2'h0, 1'b0, 3'h2, 32'h0, 16'h0010, 64'h1000, 1'b0, FLT_NONE, 16'h0);
        rd_chk(OFS_LIN_HI, 32'h0000_0001);
        rd_chk(OFS_LIN_LO, 32'h0000_1000);
        wr(OFS_GSB_HI, 32'h0000_0002);
        run(MODE_64, SR_SECOND_EXTRA_BASE, 2'h0, 1'b1, 3'h2, 32'h0, 16'h0018, 64'h10, 1'b0, FLT_NONE, 16'h0);
        rd_chk(OFS_LIN_HI, 32'h0000_0002);
        run(MODE_64, SR_EXTRA_DATA, 2'h0, 1'b0, 3'h2, 32'h0, 16'h0010, 64'h20, 1'b0, FLT_NONE, 16'h0);
        rd_chk(OFS_LIN_HI, 32'h0000_0000);
        run(MODE_COMPAT, SR_DEFAULT_DATA, 2'h0, 1'b0, 3'h2, 32'h0, 16'h0010, 64'h1000, 1'b1, FLT_LIMIT, 16'h0);
        run(MODE_COMPAT, SR_DEFAULT_DATA, 2'h3, 1'b0, 3'h2, 32'h0, 16'h0013, 64'h10, 1'b1, FLT_PRIV, 16'h0010);
        run(MODE_COMPAT, SR_DEFAULT_DATA, 2'h0, 1'b1, 3'h2, 32'h0, 16'h0010, 64'h10, 1'b1, FLT_PRIV, 16'h0);
    endtask

    task automatic t_sys();
        for (int t = 0; t < 16; t++) begin
            run(MODE_64, SR_LOCAL_TABLE, 2'h0, 1'b0, 3'h3, (32'(t) ^ 32'h2) << 8, 16'h0028, 64'h0,
                t != 2, (t == 2) ? FLT_NONE : FLT_TYPE, (t == 2) ? 16'h0 : 16'h0028);
        end
        run(MODE_64, SR_TASK_REGISTER, 2'h0, 1'b0, 3'h3, 32'h0000_0b00, 16'h0030, 64'h0, 1'b0, FLT_NONE, 16'h0);
        run(MODE_64, SR_LOCAL_TABLE, 2'h0, 1'b0, 3'h3, 32'h0, 16'h0028, 64'h0, 1'b0, FLT_NONE, 16'h0);
        rd_chk(OFS_HBASE_HI, 32'h0000_1234);
        rd_chk(OFS_HLIMIT, 32'h0000_1fff);
        run(MODE_COMPAT, SR_LOCAL_TABLE, 2'h0, 1'b0, 3'h5, 32'h0, 16'h0028, 64'h0, 1'b0, FLT_NONE, 16'h0);
        rd_chk(OFS_HBASE_HI, 32'h0000_0000);
        rd_chk(OFS_HLIMIT, 32'h0000_1fff);
        run(MODE_64, SR_LOCAL_TABLE, 2'h0, 1'b0, 3'h4, 32'h0, 16'h002b, 64'h0, 1'b1, FLT_CANON, 16'h0028);
        run(MODE_64, SR_LOCAL_TABLE, 2'h0, 1'b0, 3'h5, 32'h0, 16'h0028, 64'h0, 1'b1, FLT_TYPE, 16'h0028);
    endtask

    // watchdog far beyond the fewer than one thousand cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        conclude();
    end

    // reset for four cycles, then the scenarios in turn
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_code();
        t_data();
        t_sys();
        conclude();
    end
endmodule // ldc_descriptor_check_test
